// File: rtl/frequency_sweep_controller.sv
// Frequency sweep controller with AHB-Lite register slave
`timescale 1ns/1ps
// Functional notes
// - Each trigger in a triggered mode runs count sweeps; default 1, max 1,000,000; code ignores the count in held jump-back, one sweep per start.
// - Sweep count only used in non-continuous modes.
// - Direction up sweeps start toward stop.
// - Direction down sweeps stop toward start.
// - Continuous jump-back loops start to stop then jumps to start.
// - Triggered jump-back waits trigger, sweeps, then jumps to start.
// - Held jump-back holds stop until next trigger, then returns to start.
// - Continuous sweep-back sweeps up then down, repeating forever.
// - Triggered sweep-back waits trigger, sweeps up then back, then idles.
// - Held sweep-back holds stop until next trigger, then sweeps back.
// - Manual mode outputs manual frequency when within start/stop range.
// - Sweep time 30 ms to 1000 s, default one second.
// - Linear spacing uses equal frequency steps per unit time.
// - Log spacing uses equal time per frequency decade; code uses step 1 below 65536, sweep-back returns keep the last forward step.
module frequency_sweep_controller (
   input  wire logic        clk_sys_in,
   input  wire logic        srst_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        trigger_in,
   output logic      [31:0] freq_word_out,
   output logic             sweeping_out
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   sweep_pkg::sweep_cfg_t   cfg;
   sweep_pkg::sweep_state_t state;
   logic [31:0] start_freq;
   logic [31:0] stop_freq;
   logic [31:0] manual_freq;
   logic [19:0] time_ms;
   logic [19:0] sweep_count;
   logic [19:0] sweeps_left;
   logic [31:0] freq;
   logic [31:0] tick_cnt;
   logic [31:0] step;
   logic [31:0] updates_left;
   logic        soft_trig;
   logic        trig_meta;
   logic        trig_sync;
   logic        trig_prev;
   logic        wr_pend;
   logic [7:0]  wr_addr;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [19:0] clamp20(input logic [31:0] v, input logic [19:0] lo,
                                           input logic [19:0] hi);
      clamp20 = (v < 32'(lo)) ? lo : ((v > 32'(hi)) ? hi : v[19:0]);
   endfunction : clamp20

   function automatic logic [31:0] divu(input logic [31:0] a, input logic [31:0] b);
      divu = (b == 32'h0000_0000) ? 32'h0000_0001 : ((a / b == 32'h0) ? 32'h0000_0001 : a / b);
   endfunction : divu

   // Step toward a target, never past it and never wrapping
   function automatic logic [31:0] approach(input logic [31:0] f, input logic [31:0] s,
                                            input logic [31:0] tgt, input logic up);
      logic [32:0] sum;
      sum = {1'b0, f} + {1'b0, s};
      if (up) begin
         approach = (sum > {1'b0, tgt}) ? tgt : sum[31:0];
      end else begin
         approach = ((s > f) || (f - s < tgt)) ? tgt : f - s;
      end
   endfunction : approach

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire         bus_go    = hsel_in && hready_in && htrans_in[1];
   wire         bus_wr    = bus_go && hwrite_in;
   wire         bus_rd    = bus_go && !hwrite_in;
   wire [7:0]   rd_addr   = haddr_in[7:0];
   wire         cont_mode = (cfg.mode == sweep_pkg::MODE_CONT_JUMP) ||
                            (cfg.mode == sweep_pkg::MODE_CONT_BACK);
   wire         back_mode = (cfg.mode == sweep_pkg::MODE_CONT_BACK) ||
                            (cfg.mode == sweep_pkg::MODE_TRIG_BACK) ||
                            (cfg.mode == sweep_pkg::MODE_HELD_BACK);
   wire         held_mode = (cfg.mode == sweep_pkg::MODE_HELD_JUMP) ||
                            (cfg.mode == sweep_pkg::MODE_HELD_BACK);
   wire         manual    = (cfg.mode == sweep_pkg::MODE_MANUAL);
   wire [31:0]  lo_freq   = (start_freq < stop_freq) ? start_freq : stop_freq;
   wire [31:0]  hi_freq   = (start_freq < stop_freq) ? stop_freq : start_freq;
   wire [31:0]  from_freq = cfg.dir_down ? stop_freq : start_freq;
   wire [31:0]  to_freq   = cfg.dir_down ? start_freq : stop_freq;
   wire [31:0]  span      = hi_freq - lo_freq;
   wire [31:0]  n_updates = 32'(time_ms) * 32'(sweep_pkg::UPDATES_PER_MS);
   wire [31:0]  lin_step  = divu(span, n_updates);
   wire [31:0]  log_mul   = divu(32'(time_ms) * 32'h0000_0002, 32'h0000_0001);
   wire [31:0]  log_step  = (freq >> sweep_pkg::LOG_SHIFT[4:0]) == 32'h0 ?
                            32'h0000_0001 : divu(freq, log_mul >> 4);
   wire [31:0]  cur_step  = cfg.log_spacing ? log_step : lin_step;
   wire         tick      = (tick_cnt == 32'(sweep_pkg::UPDATE_CYCLES - 1));
   wire         trig_ev   = (trig_sync && !trig_prev) || soft_trig;
   wire         rising_up = (to_freq >= from_freq);
   wire         seg_done  = (updates_left == 32'h0000_0001);
   wire [31:0]  fwd_next  = approach(freq, step, to_freq, rising_up);
   wire [31:0]  rev_next  = approach(freq, step, from_freq, !rising_up);
   wire         man_ok    = (manual_freq >= lo_freq) && (manual_freq <= hi_freq);

   // ------------------------------------------------------------
   // Trigger synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      trig_meta <= srst_in ? 1'b0 : trigger_in;
      trig_sync <= srst_in ? 1'b0 : trig_meta;
      trig_prev <= srst_in ? 1'b0 : trig_sync;
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         wr_pend     <= 1'b0;
         wr_addr     <= 8'h00;
         hrdata_out  <= 32'h0000_0000;
         cfg         <= '{mode: sweep_pkg::MODE_CONT_JUMP, dir_down: 1'b0, log_spacing: 1'b0};
         start_freq  <= sweep_pkg::START_RST;
         stop_freq   <= sweep_pkg::STOP_RST;
         manual_freq <= sweep_pkg::MANUAL_RST;
         time_ms     <= sweep_pkg::TIME_MS_RST;
         sweep_count <= sweep_pkg::COUNT_RST;
         soft_trig   <= 1'b0;
      end else begin
         wr_pend   <= bus_wr;
         wr_addr   <= rd_addr;
         soft_trig <= 1'b0;
         if (bus_rd) begin
            case (rd_addr)
               sweep_pkg::ADDR_CTRL:    hrdata_out <= {26'h0, cfg.log_spacing, cfg.dir_down, 1'b0, cfg.mode};
               sweep_pkg::ADDR_START:   hrdata_out <= start_freq;
               sweep_pkg::ADDR_STOP:    hrdata_out <= stop_freq;
               sweep_pkg::ADDR_MANUAL:  hrdata_out <= manual_freq;
               sweep_pkg::ADDR_TIME_MS: hrdata_out <= {12'h000, time_ms};
               sweep_pkg::ADDR_COUNT:   hrdata_out <= {12'h000, sweep_count};
               sweep_pkg::ADDR_STATUS:  hrdata_out <= {10'h000, sweeps_left, state};
               sweep_pkg::ADDR_FREQ:    hrdata_out <= freq_word_out;
               default:                 hrdata_out <= 32'h0000_0000;
            endcase
         end
         if (wr_pend) begin
            case (wr_addr)
               sweep_pkg::ADDR_CTRL: begin
                  if (hwdata_in[2:0] <= 3'h6) begin
                     cfg.mode <= sweep_pkg::sweep_mode_t'(hwdata_in[2:0]);
                  end
                  cfg.dir_down    <= hwdata_in[sweep_pkg::CTRL_DIR_BIT];
                  cfg.log_spacing <= hwdata_in[sweep_pkg::CTRL_LOG_BIT];
                  soft_trig       <= hwdata_in[sweep_pkg::CTRL_TRIG_BIT];
               end
               sweep_pkg::ADDR_START:   start_freq  <= hwdata_in;
               sweep_pkg::ADDR_STOP:    stop_freq   <= hwdata_in;
               sweep_pkg::ADDR_MANUAL:  manual_freq <= hwdata_in;
               sweep_pkg::ADDR_TIME_MS: time_ms     <= clamp20(hwdata_in, sweep_pkg::TIME_MS_MIN,
                                                               sweep_pkg::TIME_MS_MAX);
               sweep_pkg::ADDR_COUNT:   sweep_count <= clamp20(hwdata_in, sweep_pkg::COUNT_RST,
                                                               sweep_pkg::COUNT_MAX);
               default: ;
            endcase
         end
      end
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;

   // ------------------------------------------------------------
   // Sweep sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         state        <= sweep_pkg::ST_IDLE;
         tick_cnt     <= 32'h0000_0000;
         freq         <= sweep_pkg::START_RST;
         step         <= 32'h0000_0001;
         updates_left <= 32'h0000_0001;
         sweeps_left  <= 20'h0_0000;
      end else begin
         tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
         if (manual) begin
            state <= sweep_pkg::ST_IDLE;
            freq  <= man_ok ? manual_freq : from_freq;
         end else begin
            case (state)
               sweep_pkg::ST_IDLE: begin
                  freq <= from_freq;
                  if (cont_mode || trig_ev) begin
                     state        <= sweep_pkg::ST_RISE;
                     step         <= cur_step;
                     updates_left <= n_updates;
                     sweeps_left  <= cont_mode ? 20'h0_0000 : sweep_count - 20'h0_0001;
                  end
               end
               sweep_pkg::ST_RISE: if (tick) begin
                  step         <= cur_step;
                  updates_left <= updates_left - 32'h0000_0001;
                  freq         <= fwd_next;
                  if (seg_done) begin
                     freq <= to_freq;
                     if (held_mode) begin
                        state <= sweep_pkg::ST_HOLD;
                     end else if (back_mode) begin
                        state        <= sweep_pkg::ST_FALL;
                        updates_left <= n_updates;
                     end else if (sweeps_left != 20'h0_0000) begin
                        sweeps_left  <= sweeps_left - 20'h0_0001;
                        freq         <= from_freq;
                        updates_left <= n_updates;
                     end else begin
                        state <= sweep_pkg::ST_IDLE;
                        freq  <= from_freq;
                     end
                  end
               end
               sweep_pkg::ST_HOLD: if (trig_ev) begin
                  if (back_mode) begin
                     state        <= sweep_pkg::ST_FALL;
                     updates_left <= n_updates;
                  end else begin
                     state <= sweep_pkg::ST_IDLE;
                     freq  <= from_freq;
                  end
               end
               sweep_pkg::ST_FALL: if (tick) begin
                  updates_left <= updates_left - 32'h0000_0001;
                  freq         <= rev_next;
                  if (seg_done) begin
                     freq <= from_freq;
                     if (sweeps_left != 20'h0_0000) begin
                        sweeps_left  <= sweeps_left - 20'h0_0001;
                        state        <= sweep_pkg::ST_RISE;
                        updates_left <= n_updates;
                     end else begin
                        state <= sweep_pkg::ST_IDLE;
                     end
                  end
               end
               default: state <= sweep_pkg::ST_IDLE;
            endcase
         end
      end
   end

   assign freq_word_out = freq;
   assign sweeping_out  = (state != sweep_pkg::ST_IDLE);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_manual_out;
      @(posedge clk_sys_in) disable iff (srst_in)
      (manual && man_ok) |=> (freq_word_out == $past(manual_freq)) || !$past(manual);
   endproperty
   a_manual_out: assert property (p_manual_out) else $error("manual frequency not output");

   property p_cont_restart;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == sweep_pkg::ST_IDLE && cont_mode && !manual) |=> (state == sweep_pkg::ST_RISE);
   endproperty
   a_cont_restart: assert property (p_cont_restart) else $error("continuous mode did not restart");

   property p_idle_wait;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == sweep_pkg::ST_IDLE && !cont_mode && !manual && !trig_ev) |=> (state == sweep_pkg::ST_IDLE);
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("sweep started without trigger");

   property p_hold_stop;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == sweep_pkg::ST_HOLD && !trig_ev && !manual) |=> (freq_word_out == $past(freq_word_out));
   endproperty
   a_hold_stop: assert property (p_hold_stop) else $error("held frequency moved");

   property p_hold_back;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == sweep_pkg::ST_HOLD && trig_ev && back_mode && !manual) |=> (state == sweep_pkg::ST_FALL);
   endproperty
   a_hold_back: assert property (p_hold_back) else $error("held sweep-back did not fall");

   property p_idle_start;
      @(posedge clk_sys_in) disable iff (srst_in)
      (state == sweep_pkg::ST_IDLE && !manual) |=> (freq_word_out == $past(from_freq));
   endproperty
   a_idle_start: assert property (p_idle_start) else $error("idle frequency not at sweep origin");

   property p_count_range;
      @(posedge clk_sys_in) disable iff (srst_in)
      (sweep_count >= sweep_pkg::COUNT_RST) && (sweep_count <= sweep_pkg::COUNT_MAX);
   endproperty
   a_count_range: assert property (p_count_range) else $error("sweep count out of range");

   property p_time_range;
      @(posedge clk_sys_in) disable iff (srst_in)
      (time_ms >= sweep_pkg::TIME_MS_MIN) && (time_ms <= sweep_pkg::TIME_MS_MAX);
   endproperty
   a_time_range: assert property (p_time_range) else $error("sweep time out of range");

   property p_tick_rate;
      @(posedge clk_sys_in) disable iff (srst_in)
      tick |=> !tick [*8];
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("update tick too frequent");
endmodule : frequency_sweep_controller

// File: rtl/sweep_pkg.sv
// Package with register map, modes and timing constants for the sweep controller
package sweep_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_START    = 8'h04;
   localparam logic [7:0] ADDR_STOP     = 8'h08;
   localparam logic [7:0] ADDR_MANUAL   = 8'h0C;
   localparam logic [7:0] ADDR_TIME_MS  = 8'h10;
   localparam logic [7:0] ADDR_COUNT    = 8'h14;
   localparam logic [7:0] ADDR_STATUS   = 8'h18;
   localparam logic [7:0] ADDR_FREQ     = 8'h1C;
   // ------------------------------------------------------------
   // Control field positions
   // ------------------------------------------------------------
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_DIR_BIT   = 4;
   localparam int CTRL_LOG_BIT   = 5;
   localparam int CTRL_TRIG_BIT  = 8;
   // ------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------
   localparam logic [31:0] START_RST    = 32'h0000_1000;
   localparam logic [31:0] STOP_RST     = 32'h0010_0000;
   localparam logic [31:0] MANUAL_RST   = 32'h0000_1000;
   localparam logic [19:0] COUNT_RST    = 20'h0_0001;
   localparam logic [19:0] COUNT_MAX    = 20'hF_4240;
   localparam logic [19:0] TIME_MS_RST  = 20'h0_03E8;
   localparam logic [19:0] TIME_MS_MIN  = 20'h0_001E;
   localparam logic [19:0] TIME_MS_MAX  = 20'hF_4240;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ         = 20000000;
   localparam int UPDATE_US      = 50;
   localparam int UPDATE_CYCLES  = (CLK_HZ / 1000000) * UPDATE_US;
   localparam int UPDATES_PER_MS = 1000 / UPDATE_US;
   localparam logic [31:0] LOG_SHIFT = 32'h0000_0010;

   typedef enum logic [2:0] {
      MODE_CONT_JUMP  = 3'h0,
      MODE_TRIG_JUMP  = 3'h1,
      MODE_HELD_JUMP  = 3'h2,
      MODE_CONT_BACK  = 3'h3,
      MODE_TRIG_BACK  = 3'h4,
      MODE_HELD_BACK  = 3'h5,
      MODE_MANUAL     = 3'h6
   } sweep_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_RISE   = 2'h1,
      ST_HOLD   = 2'h2,
      ST_FALL   = 2'h3
   } sweep_state_t;

   typedef struct packed {
      sweep_mode_t mode;
      logic        dir_down;
      logic        log_spacing;
   } sweep_cfg_t;
endpackage : sweep_pkg

// File: verif/testbench.sv
// Testbench for the frequency sweep controller
`timescale 1ns/1ps
module testbench;
   logic        clk_sys_in = 1'b0;
   logic        srst_in    = 1'b1;
   logic        hsel_in    = 1'b0;
   logic [31:0] haddr_in   = 32'h0000_0000;
   logic [1:0]  htrans_in  = 2'h0;
   logic        hwrite_in  = 1'b0;
   logic [2:0]  hsize_in   = 3'h2;
   logic [31:0] hwdata_in  = 32'h0000_0000;
   logic        fire       = 1'b0;
   logic [7:0]  fire_w     = 8'h01;
   logic        trigger_in;
   logic [31:0] hrdata_out;
   logic        hreadyout_out;
   logic        hresp_out;
   logic [31:0] freq_word_out;
   logic        sweeping_out;
   logic [31:0] f1, f2, f3;
   int          cyc;
   int          bad_count  = 0;
   int          n_checks   = 0;

   frequency_sweep_controller i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
      .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .trigger_in(trigger_in),
      .freq_word_out(freq_word_out), .sweeping_out(sweeping_out));
   trigger_source i_trig (.clk_sys_in(clk_sys_in), .fire_in(fire), .width_in(fire_w), .trig_out(trigger_in));

   initial begin
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   // -------------------------------------------------------
   // Tasks
   // -------------------------------------------------------
   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask : chk
   task automatic do_reset();
      @(posedge clk_sys_in);
      srst_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      srst_in <= 1'b0;
   endtask : do_reset
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_sys_in);
      hsel_in   <= 1'b1;
      haddr_in  <= {24'h00_0000, a};
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      hsize_in  <= 3'h2;
      do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
      hsel_in   <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
      rd = hrdata_out;
   endtask : bus
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wreg
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      chk(nm, e, x);
   endtask : rchk
   task automatic cfg(input logic [31:0] s, input logic [31:0] p);
      // Park sequencer in manual mode so the reset-time continuous sweep stops
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0006);
      wreg(sweep_pkg::ADDR_START, s);
      wreg(sweep_pkg::ADDR_STOP, p);
      wreg(sweep_pkg::ADDR_TIME_MS, 32'h0000_001E);
   endtask : cfg
   task automatic fire_trig(input logic [7:0] w);
      @(posedge clk_sys_in);
      fire_w <= w;
      fire   <= 1'b1;
      @(posedge clk_sys_in);
      fire   <= 1'b0;
   endtask : fire_trig
   task automatic step(output logic [31:0] f, output int c);
      logic [31:0] old;
      old = freq_word_out;
      c = 0;
      while (freq_word_out === old && c < 3000) begin
         @(posedge clk_sys_in);
         #1;
         c++;
      end
      if (c >= 3000) begin
         $display("mismatch freq_step expected change seen %h", old);
         bad_count++;
      end
      f = freq_word_out;
   endtask : step
   // -------------------------------------------------------
   // Tests
   // -------------------------------------------------------
   initial begin
      do_reset();
      rchk("count_rst", sweep_pkg::ADDR_COUNT, {12'h000, sweep_pkg::COUNT_RST});
      rchk("time_rst", sweep_pkg::ADDR_TIME_MS, {12'h000, sweep_pkg::TIME_MS_RST});
      rchk("freq_rst", sweep_pkg::ADDR_FREQ, sweep_pkg::START_RST);
      rchk("unmapped", 8'h40, 32'h0000_0000);
      wreg(sweep_pkg::ADDR_COUNT, 32'hFFFF_FFFF);
      rchk("count_max", sweep_pkg::ADDR_COUNT, {12'h000, sweep_pkg::COUNT_MAX});
      wreg(sweep_pkg::ADDR_COUNT, 32'h0000_0000);
      rchk("count_min", sweep_pkg::ADDR_COUNT, 32'h0000_0001);
      wreg(sweep_pkg::ADDR_TIME_MS, 32'h0000_0005);
      rchk("time_min", sweep_pkg::ADDR_TIME_MS, {12'h000, sweep_pkg::TIME_MS_MIN});
      wreg(sweep_pkg::ADDR_TIME_MS, 32'h00FF_FFFF);
      rchk("time_max", sweep_pkg::ADDR_TIME_MS, {12'h000, sweep_pkg::TIME_MS_MAX});
      for (int m = 0; m < 6; m++) begin
         do_reset();
         cfg(32'h0000_1000, 32'h0002_6800);
         wreg(sweep_pkg::ADDR_CTRL, 32'(m));
         repeat (20) @(posedge clk_sys_in);
         chk("run_no_trig", {31'h0, (m == 0 || m == 3)}, {31'h0, sweeping_out});
         fire_trig(8'h01);
         repeat (8) @(posedge clk_sys_in);
         chk("run_on_trig", 32'h1, {31'h0, sweeping_out});
      end
      // Triggered up sweep, linear, with an ignored mode code
      do_reset();
      cfg(32'h0000_1000, 32'h0002_6800);
      wreg(sweep_pkg::ADDR_COUNT, 32'h0000_0003);
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0001);
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0007);
      repeat (20) @(posedge clk_sys_in);
      chk("idle_wait", 32'h0, {31'h0, sweeping_out});
      chk("idle_freq", 32'h0000_1000, freq_word_out);
      fire_trig(8'h01);
      step(f1, cyc);
      step(f2, cyc);
      chk("step_interval", 32'(sweep_pkg::UPDATE_CYCLES), 32'(cyc));
      chk("step_up", 32'h0000_0100, f2 - f1);
      rchk("status_trig", sweep_pkg::ADDR_STATUS, 32'h0000_0009);
      fire_trig(8'h14);
      step(f3, cyc);
      chk("no_restart", 32'h0000_0100, f3 - f2);
      // Soft trigger, down sweep
      do_reset();
      cfg(32'h0000_1000, 32'h0002_6800);
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0111);
      step(f1, cyc);
      step(f2, cyc);
      chk("step_down", 32'h0000_0100, f1 - f2);
      chk("down_range", 32'h1, {31'h0, (f2 > 32'h0000_1000 && f2 < 32'h0002_6800)});
      // Continuous log sweep
      do_reset();
      cfg(32'h0010_0000, 32'h1000_0000);
      wreg(sweep_pkg::ADDR_COUNT, 32'h0000_0003);
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0020);
      step(f1, cyc);
      step(f2, cyc);
      step(f3, cyc);
      chk("log_grows", 32'h1, {31'h0, (f3 - f2 > f2 - f1)});
      chk("cont_run", 32'h1, {31'h0, sweeping_out});
      rchk("status_cont", sweep_pkg::ADDR_STATUS, 32'h0000_0001);
      // Manual frequency in and out of range
      do_reset();
      cfg(32'h0000_1000, 32'h0002_6800);
      wreg(sweep_pkg::ADDR_MANUAL, 32'h0000_2000);
      wreg(sweep_pkg::ADDR_CTRL, 32'h0000_0006);
      repeat (sweep_pkg::UPDATE_CYCLES + 100) @(posedge clk_sys_in);
      chk("manual_in", 32'h0000_2000, freq_word_out);
      wreg(sweep_pkg::ADDR_MANUAL, 32'h0003_0000);
      repeat (sweep_pkg::UPDATE_CYCLES + 100) @(posedge clk_sys_in);
      chk("manual_out", 32'h0000_1000, freq_word_out);
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk_sys_in);
      bad_count++;
      end_sim();
   end
endmodule : testbench

// File: verif/trigger_source.sv
// Trigger source model driving the asynchronous trigger pin
`timescale 1ns/1ps
module trigger_source (
   input  wire logic       clk_sys_in,
   input  wire logic       fire_in,
   input  wire logic [7:0] width_in,
   output logic            trig_out
);
   initial trig_out = 1'b0;
   // -------------------------------------------------------
   // Pulse off the clock edge, width in clock cycles
   // -------------------------------------------------------
   always @(posedge clk_sys_in) begin
      if (fire_in) begin
         #13 trig_out = 1'b1;
         repeat (width_in) @(posedge clk_sys_in);
         #13 trig_out = 1'b0;
      end
   end
endmodule : trigger_source
